/* File: rtl/bit_exec_pkg.sv */
package bit_exec_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ACC    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PC     = 8'h0c;
  localparam logic [7:0] ADDR_WDOG   = 8'h10;
  localparam logic [7:0] ADDR_FILE   = 8'h80;

  // Field positions
  localparam int CTRL_PRESC_TO_WDOG = 0;
  localparam int STAT_ZERO          = 2;
  localparam int STAT_SLEEP_N       = 3;
  localparam int STAT_EXPIRY_N      = 4;
  localparam int STAT_PAGE_LO       = 5;
  localparam int STAT_PAGE_HI       = 6;

  // Values after reset
  localparam logic [7:0]  CTRL_RESET   = 8'h01;
  localparam logic [7:0]  STATUS_RESET = 8'h18;
  localparam logic [10:0] PC_RESET     = 11'h000;

  // Cycle counts
  localparam int SKIP_CYCLES = 2;
  localparam int CALL_CYCLES = 2;

  // Instruction encodings
  localparam logic [3:0]  OPC_SKIP_LOW   = 4'h6;
  localparam logic [3:0]  OPC_SKIP_HIGH  = 4'h7;
  localparam logic [3:0]  OPC_CALL       = 4'h9;
  localparam logic [11:0] OPC_ZERO_ACC   = 12'h040;
  localparam logic [11:0] OPC_KICK       = 12'h004;
  localparam logic [6:0]  OPC_ZERO_FILE  = 7'h03;
  localparam logic [5:0]  OPC_INVERT     = 6'h09;

  typedef enum logic [2:0] {
    OP_OTHER, OP_SKIP_LOW, OP_SKIP_HIGH, OP_ZERO_ACC,
    OP_CALL, OP_KICK, OP_ZERO_FILE, OP_INVERT
  } op_t;

  typedef enum logic {ST_EXEC, ST_FLUSH} exec_state_t;

endpackage : bit_exec_pkg

/* File: rtl/dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dec_if import bit_exec_pkg::*; ;
  logic [11:0] instr;
  op_t         op;
  logic [4:0]  f;
  logic [2:0]  b;
  logic        d;
  logic [7:0]  k;
  modport decoder (input instr, output op, f, b, d, k);
  modport exec    (output instr, input op, f, b, d, k);
endinterface : dec_if
`default_nettype wire

/* File: rtl/bit_field_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_field_decode import bit_exec_pkg::*; (
  dec_if.decoder dec  // Instruction in, fields out
);

  ////////////////////////////////////////////////////////////////////////////
  // Operand fields sit at fixed places, so slice them unconditionally
  assign dec.f = dec.instr[4:0];
  assign dec.b = dec.instr[7:5];
  assign dec.d = dec.instr[5];
  assign dec.k = dec.instr[7:0];

  // Opcode classes; anything outside this group runs as a plain step
  always_comb begin
    if (dec.instr[11:8] == OPC_SKIP_LOW) begin
      dec.op = OP_SKIP_LOW;
    end else if (dec.instr[11:8] == OPC_SKIP_HIGH) begin
      dec.op = OP_SKIP_HIGH;
    end else if (dec.instr[11:8] == OPC_CALL) begin
      dec.op = OP_CALL;
    end else if (dec.instr == OPC_ZERO_ACC) begin
      dec.op = OP_ZERO_ACC;
    end else if (dec.instr == OPC_KICK) begin
      dec.op = OP_KICK;
    end else if (dec.instr[11:5] == OPC_ZERO_FILE) begin
      dec.op = OP_ZERO_FILE;
    end else if (dec.instr[11:6] == OPC_INVERT) begin
      dec.op = OP_INVERT;
    end else begin
      dec.op = OP_OTHER;
    end
  end

endmodule : bit_field_decode
`default_nettype wire

/* File: rtl/bit_skip_clear_call_exec.sv */
// How it works
// - Skip-if-bit-low tests bit b of file f, skips next when zero.
// - Skip-if-bit-high tests bit b of file f, skips next when one.
// - A skip discards the prefetched word and runs a no-op: two cycles.
// - Zero-accumulator loads 00h into accumulator and sets result-null flag.
// - Call pushes current program counter plus one onto return stack.
// - Call loads its 8-bit literal into program counter bits 7:0.
// - Call copies status bits 6:5 to counter 10:9, clears bit 8.
// - Call takes two cycles and leaves status flags alone.
// - Watchdog-kick resets the watchdog counter to 00h.
// - Watchdog-kick clears the prescaler only when assigned to watchdog.
// - Watchdog-kick sets expiry and sleep-entry flags, both active low.
// - Zero-file-register writes 00h into file f, sets result-null flag.
// - Invert-file-register complements f into accumulator or f; null flag.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module bit_skip_clear_call_exec import bit_exec_pkg::*; #(
  parameter int STACK_DEPTH = 2
) (
  input  wire logic        clk_i,         // Core clock, 250 MHz
  input  wire logic        rst_i,         // Synchronous reset, high
  input  wire logic [11:0] instr_i,       // Instruction at pc_o
  input  wire logic        instr_valid_i, // Instruction present
  output logic      [10:0] pc_o,          // Address wanted next
  output logic             retire_o,      // Instruction was executed
  output logic             discard_o,     // Flush cycle under way
  input  wire logic        wb_cyc_i,      // Wishbone cycle
  input  wire logic        wb_stb_i,      // Wishbone strobe
  input  wire logic        wb_we_i,       // Wishbone write
  input  wire logic [7:0]  wb_adr_i,      // Byte address
  input  wire logic [3:0]  wb_sel_i,      // Byte enables
  input  wire logic [31:0] wb_dat_i,      // Write data
  output logic      [31:0] wb_dat_o,      // Read data
  output logic             wb_ack_o       // Acknowledge
);

  typedef struct packed {
    exec_state_t                   state;
    logic                          flush_advance;
    logic [10:0]                   pc;
    logic [STACK_DEPTH-1:0][10:0]  stack;
    logic [7:0]                    acc;
    logic [7:0]                    status;
    logic [7:0]                    ctrl;
    logic [7:0]                    wdt;
    logic [7:0]                    prescaler;
    logic [31:0][7:0]              file;
    logic                          ack;
    logic [31:0]                   rdata;
    logic                          retire;
    logic                          discard;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  dec_if dec ();

  logic        take;
  logic        bit_sel;
  logic [7:0]  file_val;
  logic [7:0]  inverted;
  logic [10:0] call_target;
  logic [10:0] return_addr;
  logic        wdt_tick;
  logic        bus_req;
  logic        bus_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode lives in its own module
  assign dec.instr = instr_i;

  bit_field_decode u_decode (
    .dec (dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand values shared by execution and checks
  assign take        = (st.state == ST_EXEC) && instr_valid_i;
  assign file_val    = st.file[dec.f];
  assign bit_sel     = file_val[dec.b];
  assign inverted    = ~file_val;
  assign return_addr = st.pc + 11'h001;
  assign call_target = {st.status[STAT_PAGE_HI:STAT_PAGE_LO], 1'b0, dec.k};
  // Prescaler feeds the watchdog only while assigned to it
  assign wdt_tick    = !st.ctrl[CTRL_PRESC_TO_WDOG] ||
                       (st.prescaler == 8'hff);
  assign bus_req     = wb_cyc_i && wb_stb_i && !st.ack;
  assign bus_wr      = bus_req && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus, then time base, then instruction. An expiry beats a
  // software status write; an instruction's flags beat both.
  always_comb begin
    next_st         = st;
    next_st.retire  = 1'b0;
    next_st.discard = 1'b0;

    // Bus slave: answer one cycle after the strobe, unmapped reads zero
    next_st.ack   = bus_req;
    if (bus_req) begin
      next_st.rdata = 32'h0000_0000;
      if (wb_adr_i[7] == ADDR_FILE[7]) begin
        next_st.rdata[7:0] = st.file[wb_adr_i[6:2]];
      end else begin
        case (wb_adr_i)
          ADDR_CTRL:   next_st.rdata[7:0]  = st.ctrl;
          ADDR_ACC:    next_st.rdata[7:0]  = st.acc;
          ADDR_STATUS: next_st.rdata[7:0]  = st.status;
          ADDR_PC:     next_st.rdata[10:0] = st.pc;
          ADDR_WDOG:   next_st.rdata[15:0] = {st.prescaler, st.wdt};
          default:     next_st.rdata       = 32'h0000_0000;
        endcase
      end
    end
    if (bus_wr) begin
      if (wb_adr_i[7] == ADDR_FILE[7]) begin
        next_st.file[wb_adr_i[6:2]] = wb_dat_i[7:0];
      end else begin
        case (wb_adr_i)
          ADDR_CTRL:   next_st.ctrl   = wb_dat_i[7:0];
          ADDR_ACC:    next_st.acc    = wb_dat_i[7:0];
          ADDR_STATUS: next_st.status = wb_dat_i[7:0];
          default:     next_st.ctrl   = next_st.ctrl;
        endcase
      end
    end

    // Watchdog time base; its expiry must not be lost to a bus write
    next_st.prescaler = st.prescaler + 8'h01;
    if (wdt_tick) begin
      next_st.wdt = st.wdt + 8'h01;
      if (st.wdt == 8'hff) begin
        next_st.status[STAT_EXPIRY_N] = 1'b0;
      end
    end

    // Instruction sequencing
    case (st.state)
      ST_EXEC: begin
        if (instr_valid_i) begin
          next_st.retire = 1'b1;
          next_st.pc     = return_addr;
          case (dec.op)
            OP_SKIP_LOW: begin
              if (!bit_sel) begin
                next_st.state         = ST_FLUSH;
                next_st.flush_advance = 1'b1;
                next_st.discard       = 1'b1;
              end
            end
            OP_SKIP_HIGH: begin
              if (bit_sel) begin
                next_st.state         = ST_FLUSH;
                next_st.flush_advance = 1'b1;
                next_st.discard       = 1'b1;
              end
            end
            OP_ZERO_ACC: begin
              next_st.acc              = 8'h00;
              next_st.status[STAT_ZERO] = 1'b1;
            end
            OP_CALL: begin
              // Push shifts older entries down; the deepest is lost
              for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                next_st.stack[i] = st.stack[i-1];
              end
              next_st.stack[0]      = return_addr;
              next_st.pc            = call_target;
              next_st.state         = ST_FLUSH;
              next_st.flush_advance = 1'b0;
              next_st.discard       = 1'b1;
            end
            OP_KICK: begin
              next_st.wdt = 8'h00;
              if (st.ctrl[CTRL_PRESC_TO_WDOG]) begin
                next_st.prescaler = 8'h00;
              end
              next_st.status[STAT_EXPIRY_N] = 1'b1;
              next_st.status[STAT_SLEEP_N]  = 1'b1;
            end
            OP_ZERO_FILE: begin
              next_st.file[dec.f]       = 8'h00;
              next_st.status[STAT_ZERO] = 1'b1;
            end
            OP_INVERT: begin
              if (dec.d) begin
                next_st.file[dec.f] = inverted;
              end else begin
                next_st.acc = inverted;
              end
              next_st.status[STAT_ZERO] = (inverted == 8'h00);
            end
            default: begin
              // Words outside this group run as a one-cycle no-op
              next_st.retire = 1'b1;
            end
          endcase
        end
      end
      ST_FLUSH: begin
        // Prefetched word is dropped; a skip also steps over its address
        next_st.state = ST_EXEC;
        if (st.flush_advance) begin
          next_st.pc = return_addr;
        end
      end
      default: begin
        next_st.state = ST_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st        <= '0;
      st.pc     <= PC_RESET;
      st.status <= STATUS_RESET;
      st.ctrl   <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign pc_o      = st.pc;
  assign retire_o  = st.retire;
  assign discard_o = st.discard;
  assign wb_dat_o  = st.rdata;
  assign wb_ack_o  = st.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_skip_low;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_SKIP_LOW && !bit_sel
      |=> st.state == ST_FLUSH && discard_o ##1 st.state == ST_EXEC;
  endproperty
  a_skip_low: assert property (p_skip_low)
    else $error("bit-low skip did not flush exactly one cycle");

  property p_skip_high_none;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_SKIP_HIGH && !bit_sel
      |=> st.state == ST_EXEC && !discard_o && pc_o == $past(return_addr);
  endproperty
  a_skip_high_none: assert property (p_skip_high_none)
    else $error("bit-high test skipped on a clear bit");

  property p_skip_advance;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_SKIP_HIGH && bit_sel
      |=> ##1 pc_o == $past(return_addr, 2) + 11'h001;
  endproperty
  a_skip_advance: assert property (p_skip_advance)
    else $error("skip did not step over the next address");

  property p_zero_acc;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_ZERO_ACC
      |=> st.acc == 8'h00 && st.status[STAT_ZERO] && st.state == ST_EXEC;
  endproperty
  a_zero_acc: assert property (p_zero_acc)
    else $error("accumulator clear failed");

  property p_call_push;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_CALL |=> st.stack[0] == $past(return_addr);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call pushed a wrong return address");

  property p_call_target;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_CALL
      |=> pc_o == $past(call_target) && !pc_o[8]
      ##1 $stable(pc_o) && st.state == ST_EXEC;
  endproperty
  a_call_target: assert property (p_call_target)
    else $error("call target or its two-cycle timing is wrong");

  property p_kick;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_KICK
      |=> st.wdt == 8'h00 && st.status[STAT_EXPIRY_N]
          && st.status[STAT_SLEEP_N];
  endproperty
  a_kick: assert property (p_kick)
    else $error("watchdog kick missed counter or flags");

  property p_kick_presc;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_KICK && !st.ctrl[CTRL_PRESC_TO_WDOG]
      |=> st.prescaler == $past(st.prescaler) + 8'h01;
  endproperty
  a_kick_presc: assert property (p_kick_presc)
    else $error("prescaler cleared while owned by the timer");

  property p_zero_file;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_ZERO_FILE
      |=> st.file[$past(dec.f)] == 8'h00 && st.status[STAT_ZERO];
  endproperty
  a_zero_file: assert property (p_zero_file)
    else $error("file register clear failed");

  property p_invert_acc;
    @(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_INVERT && !dec.d
      |=> st.acc == $past(inverted)
          && st.status[STAT_ZERO] == ($past(inverted) == 8'h00);
  endproperty
  a_invert_acc: assert property (p_invert_acc)
    else $error("complement to accumulator wrong");

  c_skip: cover property (@(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_SKIP_LOW && !bit_sel);
  c_call: cover property (@(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_CALL);
  c_invert_file: cover property (@(posedge clk_i) disable iff (rst_i)
    take && dec.op == OP_INVERT && dec.d);

endmodule : bit_skip_clear_call_exec
`default_nettype wire

/* File: verif/bit_skip_clear_call_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_skip_clear_call_exec_tb import bit_exec_pkg::*; ;
  logic        clk_i;
  logic        rst_i;
  logic [11:0] instr_i;
  logic        instr_valid_i;
  logic [10:0] pc_o;
  logic        retire_o;
  logic        discard_o;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  int          n_mismatch;
  int          comparisons;
  integer      seed;
  logic [10:0] pc_exp;
  logic [31:0] q;
  logic [31:0] pre;
  logic [7:0]  v, a, r, st, k;
  logic [4:0]  f;
  logic [2:0]  b;
  logic        d, hit;
  logic [1:0]  pg;

  bit_skip_clear_call_exec u_bit_skip_clear_call_exec (
    .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .pc_o(pc_o), .retire_o(retire_o),
    .discard_o(discard_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Closing verdict, shared by the sequence and the watchdog
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // File register byte address
  function automatic logic [7:0] fa(input logic [4:0] fi);
    return 8'h80 | {1'b0, fi, 2'b00};
  endfunction : fa

  // Classic cycle; held until ack is sampled high, only the watchdog
  // ends a wait that never gets its answer
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] dat, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    // Slave must let ack go in the cycle after it gave it
    @(posedge clk_i);
    chk("wb_ack_o", 32'h0, {31'h0, wb_ack_o});
  endtask : wb

  // One instruction; p1 is pc after the taking edge, p2 after any flush
  task automatic exec(input logic [11:0] w, input logic two,
                      input logic [10:0] p1, input logic [10:0] p2);
    @(posedge clk_i);
    instr_i       <= w;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    instr_i       <= ~w;
    #1;
    chk("retire_o", 32'h1, {31'h0, retire_o});
    chk("discard_o", {31'h0, two}, {31'h0, discard_o});
    chk("pc_o", {21'h0, p1}, {21'h0, pc_o});
    if (two) begin
      @(posedge clk_i);
      #1;
      chk("discard_o end", 32'h0, {31'h0, discard_o});
      chk("retire_o end", 32'h0, {31'h0, retire_o});
      chk("pc_o end", {21'h0, p2}, {21'h0, pc_o});
    end
    pc_exp = p2;
  endtask : exec

  // Hang guard, well above the expected run of a few thousand cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    seed = 32'h901cab90;
    rst_i = 1'b1;
    instr_i = 12'h000;
    instr_valid_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    pc_exp = PC_RESET;
    chk("pc reset", {21'h0, PC_RESET}, {21'h0, pc_o});
    wb(1'b0, ADDR_STATUS, 8'h00, q);
    chk("status reset", {24'h0, STATUS_RESET}, {24'h0, q[7:0]});
    wb(1'b0, ADDR_CTRL, 8'h00, q);
    chk("ctrl reset", {24'h0, CTRL_RESET}, {24'h0, q[7:0]});
    wb(1'b0, 8'h40, 8'h00, q);
    chk("unmapped", 32'h0, q);
    // Random operands, with all-ones and all-zeros data first
    for (int i = 0; i < 40; i++) begin
      f = 5'($random(seed));
      b = 3'($random(seed));
      d = 1'($random(seed));
      a = 8'($random(seed));
      k = (i == 2) ? 8'hff : 8'($random(seed));
      pg = 2'($random(seed));
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      r = ~v;
      wb(1'b1, fa(f), v, q);
      hit = ~v[b];
      exec({OPC_SKIP_LOW, b, f}, hit, pc_exp + 11'h001,
           pc_exp + 11'h001 + {10'h000, hit});
      hit = v[b];
      exec({OPC_SKIP_HIGH, b, f}, hit, pc_exp + 11'h001,
           pc_exp + 11'h001 + {10'h000, hit});
      wb(1'b1, ADDR_ACC, a | 8'h01, q);
      wb(1'b1, ADDR_STATUS, 8'h00, q);
      exec(OPC_ZERO_ACC, 1'b0, pc_exp + 11'h001, pc_exp + 11'h001);
      wb(1'b0, ADDR_ACC, 8'h00, q);
      chk("acc zero", 32'h0, {24'h0, q[7:0]});
      wb(1'b0, ADDR_STATUS, 8'h00, q);
      chk("null flag", 32'h1, {31'h0, q[STAT_ZERO]});
      // Null flag is preset opposite to the expected result
      wb(1'b1, ADDR_ACC, a, q);
      wb(1'b1, ADDR_STATUS, {5'h00, r != 8'h00, 2'b00}, q);
      exec({OPC_INVERT, d, f}, 1'b0, pc_exp + 11'h001,
           pc_exp + 11'h001);
      wb(1'b0, fa(f), 8'h00, q);
      chk("file after invert", {24'h0, d ? r : v}, {24'h0, q[7:0]});
      wb(1'b0, ADDR_ACC, 8'h00, q);
      chk("acc after invert", {24'h0, d ? a : r}, {24'h0, q[7:0]});
      wb(1'b0, ADDR_STATUS, 8'h00, q);
      chk("invert null", {31'h0, r == 8'h00}, {31'h0, q[STAT_ZERO]});
      exec({OPC_ZERO_FILE, f}, 1'b0, pc_exp + 11'h001,
           pc_exp + 11'h001);
      wb(1'b0, fa(f), 8'h00, q);
      chk("file zero", 32'h0, {24'h0, q[7:0]});
      wb(1'b0, ADDR_STATUS, 8'h00, q);
      chk("file null", 32'h1, {31'h0, q[STAT_ZERO]});
      st = {1'b0, pg, 5'($random(seed))};
      wb(1'b1, ADDR_STATUS, st, q);
      exec({OPC_CALL, k}, 1'b1, {pg, 1'b0, k}, {pg, 1'b0, k});
      wb(1'b0, ADDR_STATUS, 8'h00, q);
      chk("status after call", {24'h0, st}, {24'h0, q[7:0]});
    end
    // Kick with prescaler on the watchdog, then on the timer
    for (int j = 0; j < 2; j++) begin
      wb(1'b1, ADDR_CTRL, (j == 0) ? 8'h01 : 8'h00, q);
      repeat (20 + ($random(seed) & 127)) @(posedge clk_i);
      wb(1'b1, ADDR_STATUS, 8'h00, q);
      wb(1'b0, ADDR_WDOG, 8'h00, pre);
      exec(OPC_KICK, 1'b0, pc_exp + 11'h001, pc_exp + 11'h001);
      wb(1'b0, ADDR_WDOG, 8'h00, q);
      if (j == 0) begin
        chk("wdog count", 32'h0, {24'h0, q[7:0]});
        chk("prescaler cleared", 32'h1, {31'h0, q[15:8] < 8'h08});
      end else begin
        chk("wdog count", 32'h1, {31'h0, q[7:0] < 8'h08});
        if (pre[15:8] != 8'h00 && pre[15:8] < 8'hf0) begin
          chk("prescaler kept", 32'h1, {31'h0, q[15:8] != 8'h00});
        end
      end
      wb(1'b0, ADDR_STATUS, 8'h00, q);
      chk("flags_n", 32'h3, {30'h0, q[STAT_EXPIRY_N], q[STAT_SLEEP_N]});
    end
    summarize();
  end
endmodule : bit_skip_clear_call_exec_tb
`default_nettype wire
